//--- src/wss_params.svh
// constants of the winding select supervisor: offsets, fields, times
// assumes a 100 MHz core clock and byte addresses on the register port
`ifndef WSS_PARAMS_SVH
`define WSS_PARAMS_SVH

`define WSS_CLK_KHZ 100000
`define WSS_CHANGE_TIMEOUT_MS 2000
`define WSS_POWER_CHECK_MS 100
`define WSS_CHANGE_CYCLES (`WSS_CHANGE_TIMEOUT_MS * `WSS_CLK_KHZ)
`define WSS_CHECK_CYCLES (`WSS_POWER_CHECK_MS * `WSS_CLK_KHZ)
`define WSS_TMR_W 28

`define WSS_ADDR_CTRL 8'h00
`define WSS_ADDR_CONFIG 8'h04
`define WSS_ADDR_LOW_MAX 8'h08
`define WSS_ADDR_STATE 8'h0C
`define WSS_ADDR_INT_STATUS 8'h10
`define WSS_ADDR_INT_MASK 8'h14

`define WSS_CTRL_ALARM_RESET 0
`define WSS_CTRL_STOP_LSB 1
`define WSS_CTRL_STOP_MSB 2
`define WSS_CFG_TYPE_MSB 2
`define WSS_CFG_WINDING 3
`define WSS_LOW_MAX_RESET 16'hFFFF

`define WSS_AL_TYPE 0
`define WSS_AL_WINDING 1
`define WSS_AL_PAIRING 2
`define WSS_AL_OVERSPEED 3
`define WSS_AL_SELECTOR 4
`define WSS_AL_POLE 5
`define WSS_AL_LATCHED 6'h17
`define WSS_EV_POLE_DONE 6
`define WSS_N_ALARMS 6
`define WSS_N_EVENTS 7

`define WSS_ST_POLE_OK 8
`define WSS_ST_SERVO 9
`define WSS_ST_FB 10
`define WSS_ST_FSM_LSB 12

`define WSS_IO_WINDING_BIT 31
`define WSS_WINDING_HIGH 1'b0
`define WSS_WINDING_LOW 1'b1

`endif

//--- src/wss_pkg.sv
// types shared by the winding select supervisor
// assumes wss_params.svh supplies all numeric constants
package wss_pkg;
	typedef enum logic [2:0] {
		WSS_CHECK = 3'h0,
		WSS_IDLE = 3'h1,
		WSS_POLE = 3'h2,
		WSS_RUN = 3'h3,
		WSS_CHANGE = 3'h4
	} wss_state_t;
endpackage

//--- src/wss_timer.sv
// one-shot down counter for changeover and power-on check limits
// assumes load and stop are never high together with a zero load value
`timescale 1ns/1ps
`include "wss_params.svh"
module wss_timer (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	// control
	input wire logic i_load,
	input wire logic i_stop,
	input wire logic [`WSS_TMR_W-1:0] i_value,
	// result
	output logic o_expired
);
	logic [`WSS_TMR_W-1:0] count;
	logic running;
	logic [`WSS_TMR_W-1:0] next_count;
	logic next_running;
	logic next_expired;

	always_comb begin
		next_count = count;
		next_running = running;
		next_expired = 1'b0;
		if (i_load) begin
			next_count = i_value;
			next_running = 1'b1;
		end else if (i_stop) begin
			next_running = 1'b0;
		end else if (running) begin
			next_count = count - `WSS_TMR_W'(1);
			if (count == `WSS_TMR_W'(1)) begin
				next_running = 1'b0;
				next_expired = 1'b1;
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_reset_n) begin
			count <= '0;
			running <= 1'b0;
			o_expired <= 1'b0;
		end else begin
			count <= next_count;
			running <= next_running;
			o_expired <= next_expired;
		end
	end
endmodule // wss_timer

//--- src/wss_irq.sv
// sticky event flags, write-one-to-clear, with mask and level interrupt
// assumes event pulses and register writes arrive on the core clock
`timescale 1ns/1ps
`include "wss_params.svh"
module wss_irq (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	// events and software access
	input wire logic [`WSS_N_EVENTS-1:0] i_event,
	input wire logic i_status_wr,
	input wire logic i_mask_wr,
	input wire logic [`WSS_N_EVENTS-1:0] i_wdata,
	// state
	output logic [`WSS_N_EVENTS-1:0] o_status,
	output logic [`WSS_N_EVENTS-1:0] o_mask,
	output logic o_irq
);
	logic [`WSS_N_EVENTS-1:0] next_status;
	logic [`WSS_N_EVENTS-1:0] next_mask;

	always_comb begin
		next_status = o_status;
		next_mask = o_mask;
		if (i_status_wr)
			next_status = next_status & ~i_wdata;
		// a new event beats a clear in the same cycle
		next_status = next_status | i_event;
		if (i_mask_wr)
			next_mask = i_wdata;
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_reset_n) begin
			o_status <= '0;
			o_mask <= '0;
			o_irq <= 1'b0;
		end else begin
			o_status <= next_status;
			o_mask <= next_mask;
			o_irq <= |(next_status & next_mask);
		end
	end
endmodule // wss_irq

//--- src/wss_supervisor.sv
// winding select supervisor: pole detection sequencing, changeover, alarms
// assumes synchronous inputs; register port answers reads one cycle later
// Operation
// - first servo-on after power-up starts magnetic pole detection.
// - servo enabled and completion reported only after pole detection.
// - pole detection runs only with the low-speed winding connected.
// - motor type setting differing from motor data latches a type alarm.
// - winding setting differing from motor data latches a winding alarm.
// - unsupported amplifier and motor pairing latches a pairing alarm.
// - overspeed on the low-speed winding raises a self-clearing alarm.
// - selector not following command at power-on latches selector fault.
// - changeover not done within two seconds latches selector fault.
// - selector chatter with no command pending latches selector fault.
// - servo-on before pole detection completes raises a self-clearing alarm.
// - pole detection on the high-speed winding raises the same alarm.
// - command bit 31 selects winding, 0 high speed, 1 low speed.
// - status bit 31 reports active winding, 0 high, 1 low.
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "wss_params.svh"
module wss_supervisor #(
	parameter int CHANGE_CYCLES = `WSS_CHANGE_CYCLES,
	parameter int CHECK_CYCLES = `WSS_CHECK_CYCLES
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	// register port
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	// host servo command and status words
	input wire logic i_servo_enable_command,
	input wire logic [31:0] i_servo_cmd_io,
	output logic [31:0] o_status_io,
	output logic o_servo_on_done,
	// motor, selector and pole detection
	input wire logic [2:0] i_motor_param_type,
	input wire logic i_motor_param_winding,
	input wire logic i_pairing_ok,
	input wire logic [15:0] i_motor_speed,
	input wire logic i_selector_fb,
	input wire logic i_pole_done,
	output logic o_pole_detect_req,
	output logic o_selector_cmd,
	output logic o_servo_enabled,
	// alarms and stop
	output logic [`WSS_N_ALARMS-1:0] o_alarm,
	output logic o_stop_req,
	output logic [1:0] o_alarm_stop_method,
	output logic o_irq
);
	wss_pkg::wss_state_t state, next_state;
	logic pole_ok, next_pole_ok;
	logic fb_prev;
	logic winding_active, next_winding_active;
	logic next_pole_req, next_sel_cmd, next_servo, next_done;
	logic [`WSS_N_ALARMS-1:0] next_alarm, cause;
	logic [2:0] motor_type_setting;
	logic winding_select_setting;
	logic [1:0] next_stop_method;
	logic [15:0] low_max_speed;
	logic [31:0] next_rdata;
	logic tmr_load, tmr_stop, tmr_expired;
	logic [`WSS_TMR_W-1:0] tmr_value;
	logic alarm_reset, req_low, any_alarm, start_pole;
	logic [`WSS_N_EVENTS-1:0] irq_status, irq_mask, irq_event;

	function automatic logic is_low(input logic w);
		return w == `WSS_WINDING_LOW;
	endfunction

	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		return a == o;
	endfunction

	assign req_low = i_servo_cmd_io[`WSS_IO_WINDING_BIT];
	assign alarm_reset = i_wr && hit(i_addr, `WSS_ADDR_CTRL)
		&& i_wdata[`WSS_CTRL_ALARM_RESET];
	assign any_alarm = |o_alarm;
	assign start_pole = state == wss_pkg::WSS_IDLE && i_servo_enable_command
		&& !pole_ok && !any_alarm && is_low(req_low)
		&& is_low(i_selector_fb);

	// alarm causes
	always_comb begin
		cause = '0;
		cause[`WSS_AL_TYPE] = motor_type_setting != i_motor_param_type;
		cause[`WSS_AL_WINDING] =
			winding_select_setting != i_motor_param_winding;
		cause[`WSS_AL_PAIRING] = !i_pairing_ok;
		cause[`WSS_AL_OVERSPEED] = is_low(winding_active)
			&& i_motor_speed > low_max_speed;
		cause[`WSS_AL_SELECTOR] =
			(state == wss_pkg::WSS_CHECK && tmr_expired)
			|| (state == wss_pkg::WSS_CHANGE && tmr_expired)
			|| (state != wss_pkg::WSS_CHECK
			&& state != wss_pkg::WSS_CHANGE
			&& i_selector_fb != fb_prev);
		// servo asked for while pole detection is not done and not running, or pole detection running on a high-speed request
		cause[`WSS_AL_POLE] = i_servo_enable_command && !pole_ok
			&& state != wss_pkg::WSS_POLE && !start_pole
			|| state == wss_pkg::WSS_POLE && !is_low(req_low);
	end

	// latched alarms hold until reset, self-clearing ones follow the cause
	always_comb begin
		next_alarm = o_alarm & `WSS_AL_LATCHED;
		if (alarm_reset)
			next_alarm = '0;
		next_alarm = next_alarm | cause;
	end

	// sequencer
	always_comb begin
		next_state = state;
		next_pole_ok = pole_ok;
		next_sel_cmd = o_selector_cmd;
		tmr_load = 1'b0;
		tmr_stop = 1'b0;
		tmr_value = `WSS_TMR_W'(CHANGE_CYCLES);
		unique case (state)
			wss_pkg::WSS_CHECK: begin
				if (is_low(i_selector_fb) || tmr_expired) begin
					tmr_stop = 1'b1;
					next_state = wss_pkg::WSS_IDLE;
				end
			end
			wss_pkg::WSS_IDLE: begin
				if (start_pole) begin
					next_state = wss_pkg::WSS_POLE;
				end else if (pole_ok && req_low != o_selector_cmd) begin
					next_sel_cmd = req_low;
					tmr_load = 1'b1;
					next_state = wss_pkg::WSS_CHANGE;
				end else if (pole_ok && i_servo_enable_command
					&& !any_alarm) begin
					next_state = wss_pkg::WSS_RUN;
				end
			end
			wss_pkg::WSS_POLE: begin
				if (any_alarm || !i_servo_enable_command
					|| !is_low(req_low) || !is_low(i_selector_fb)) begin
					next_state = wss_pkg::WSS_IDLE;
				end else if (i_pole_done) begin
					next_pole_ok = 1'b1;
					next_state = wss_pkg::WSS_RUN;
				end
			end
			wss_pkg::WSS_RUN: begin
				if (any_alarm || !i_servo_enable_command) begin
					next_state = wss_pkg::WSS_IDLE;
				end else if (req_low != o_selector_cmd) begin
					// servo drops for the changeover, contactor moves unloaded
					next_sel_cmd = req_low;
					tmr_load = 1'b1;
					next_state = wss_pkg::WSS_CHANGE;
				end
			end
			wss_pkg::WSS_CHANGE: begin
				if (i_selector_fb == o_selector_cmd || tmr_expired) begin
					tmr_stop = 1'b1;
					next_state = wss_pkg::WSS_IDLE;
				end
			end
			default: next_state = wss_pkg::WSS_IDLE;
		endcase
		next_pole_req = next_state == wss_pkg::WSS_POLE;
		next_servo = next_state == wss_pkg::WSS_RUN && pole_ok | next_pole_ok;
		next_done = next_servo;
		// status follows the contactor only once it agrees with the command
		next_winding_active = i_selector_fb == o_selector_cmd
			? o_selector_cmd : winding_active;
	end

	// register port
	always_comb begin
		next_rdata = '0;
		if (i_rd) begin
			unique case (i_addr)
				`WSS_ADDR_CTRL:
					next_rdata[`WSS_CTRL_STOP_MSB:`WSS_CTRL_STOP_LSB] =
						o_alarm_stop_method;
				`WSS_ADDR_CONFIG:
					next_rdata[`WSS_CFG_WINDING:0] =
						{winding_select_setting, motor_type_setting};
				`WSS_ADDR_LOW_MAX: next_rdata[15:0] = low_max_speed;
				`WSS_ADDR_STATE: begin
					next_rdata[`WSS_N_ALARMS-1:0] = o_alarm;
					next_rdata[`WSS_ST_POLE_OK] = pole_ok;
					next_rdata[`WSS_ST_SERVO] = o_servo_enabled;
					next_rdata[`WSS_ST_FB] = i_selector_fb;
					next_rdata[`WSS_ST_FSM_LSB+:3] = state;
				end
				`WSS_ADDR_INT_STATUS:
					next_rdata[`WSS_N_EVENTS-1:0] = irq_status;
				`WSS_ADDR_INT_MASK:
					next_rdata[`WSS_N_EVENTS-1:0] = irq_mask;
				default: next_rdata = '0;
			endcase
		end
		next_stop_method = o_alarm_stop_method;
		if (i_wr && hit(i_addr, `WSS_ADDR_CTRL))
			next_stop_method =
				i_wdata[`WSS_CTRL_STOP_MSB:`WSS_CTRL_STOP_LSB];
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_reset_n) begin
			state <= wss_pkg::WSS_CHECK;
			pole_ok <= 1'b0;
			fb_prev <= `WSS_WINDING_LOW;
			winding_active <= `WSS_WINDING_LOW;
			o_pole_detect_req <= 1'b0;
			o_selector_cmd <= `WSS_WINDING_LOW;
			o_servo_enabled <= 1'b0;
			o_servo_on_done <= 1'b0;
			o_alarm <= '0;
			o_stop_req <= 1'b0;
			o_alarm_stop_method <= '0;
			o_status_io <= '0;
			o_rdata <= '0;
			motor_type_setting <= '0;
			winding_select_setting <= 1'b0;
			low_max_speed <= `WSS_LOW_MAX_RESET;
		end else begin
			state <= next_state;
			pole_ok <= next_pole_ok;
			fb_prev <= i_selector_fb;
			winding_active <= next_winding_active;
			o_pole_detect_req <= next_pole_req;
			o_selector_cmd <= next_sel_cmd;
			o_servo_enabled <= next_servo && !(|next_alarm);
			o_servo_on_done <= next_done && !(|next_alarm);
			o_alarm <= next_alarm;
			o_stop_req <= |next_alarm;
			o_alarm_stop_method <= next_stop_method;
			o_status_io <= {next_winding_active, 31'h0};
			o_rdata <= next_rdata;
			if (i_wr && hit(i_addr, `WSS_ADDR_CONFIG))
				{winding_select_setting, motor_type_setting} <=
					i_wdata[`WSS_CFG_WINDING:0];
			if (i_wr && hit(i_addr, `WSS_ADDR_LOW_MAX))
				low_max_speed <= i_wdata[15:0];
		end
	end

	// power-on check starts at reset release via the load below
	logic check_armed;
	always_ff @(posedge i_core_clk) begin
		if (!i_reset_n)
			check_armed <= 1'b0;
		else
			check_armed <= 1'b1;
	end

	wss_timer u_timer (
		.i_core_clk(i_core_clk),
		.i_reset_n(i_reset_n),
		.i_load(tmr_load || !check_armed),
		.i_stop(tmr_stop),
		.i_value(check_armed ? tmr_value : `WSS_TMR_W'(CHECK_CYCLES)),
		.o_expired(tmr_expired)
	);

	assign irq_event = {next_pole_ok & ~pole_ok, next_alarm & ~o_alarm};

	wss_irq u_irq (
		.i_core_clk(i_core_clk),
		.i_reset_n(i_reset_n),
		.i_event(irq_event),
		.i_status_wr(i_wr && hit(i_addr, `WSS_ADDR_INT_STATUS)),
		.i_mask_wr(i_wr && hit(i_addr, `WSS_ADDR_INT_MASK)),
		.i_wdata(i_wdata[`WSS_N_EVENTS-1:0]),
		.o_status(irq_status),
		.o_mask(irq_mask),
		.o_irq(o_irq)
	);

	first_on_pole_a: assert property (
		@(posedge i_core_clk) disable iff (!i_reset_n)
		start_pole |=> o_pole_detect_req)
		else $error("first servo-on did not start pole detection");
	servo_after_pole_a: assert property (
		@(posedge i_core_clk) disable iff (!i_reset_n)
		o_servo_on_done |-> pole_ok && o_servo_enabled)
		else $error("servo reported on before pole detection");
	pole_low_wind_a: assert property (
		@(posedge i_core_clk) disable iff (!i_reset_n)
		o_pole_detect_req |-> $past(i_selector_fb) == `WSS_WINDING_LOW)
		else $error("pole detection on high-speed winding");
	pole_high_wind_a: assert property (
		@(posedge i_core_clk) disable iff (!i_reset_n)
		state == wss_pkg::WSS_POLE && !is_low(req_low)
		|=> !o_pole_detect_req && o_alarm[`WSS_AL_POLE])
		else $error("pole detection not aborted on high-speed request");
	type_mismatch_a: assert property (
		@(posedge i_core_clk) disable iff (!i_reset_n)
		motor_type_setting != i_motor_param_type
		|=> o_alarm[`WSS_AL_TYPE] && o_stop_req)
		else $error("type mismatch alarm missing");
	low_overspeed_a: assert property (
		@(posedge i_core_clk) disable iff (!i_reset_n)
		!cause[`WSS_AL_OVERSPEED] |=> !o_alarm[`WSS_AL_OVERSPEED])
		else $error("overspeed alarm did not clear");
	change_timeout_a: assert property (
		@(posedge i_core_clk) disable iff (!i_reset_n)
		state == wss_pkg::WSS_CHANGE && tmr_expired
		|=> o_alarm[`WSS_AL_SELECTOR] ##1 o_alarm[`WSS_AL_SELECTOR])
		else $error("changeover timeout not latched");
	selector_chatter_a: assert property (
		@(posedge i_core_clk) disable iff (!i_reset_n)
		state == wss_pkg::WSS_RUN && $changed(i_selector_fb)
		|-> ##1 o_alarm[`WSS_AL_SELECTOR] ##1 !o_servo_enabled)
		else $error("selector chatter not flagged");
	status_wind_a: assert property (
		@(posedge i_core_clk) disable iff (!i_reset_n)
		state == wss_pkg::WSS_CHANGE && i_selector_fb == o_selector_cmd
		|=> o_status_io[`WSS_IO_WINDING_BIT] == $past(o_selector_cmd))
		else $error("status winding bit wrong");
	latch_hold_a: assert property (
		@(posedge i_core_clk) disable iff (!i_reset_n)
		o_alarm[`WSS_AL_PAIRING] && !alarm_reset
		|=> o_alarm[`WSS_AL_PAIRING])
		else $error("latched alarm cleared without reset");
endmodule // wss_supervisor

//--- verif/wss_motor_model.sv
// motor-side model: winding contactor feedback and pole detection unit
// assumes the supervisor drives the selector command and the pole request
`timescale 1ns/1ps
module wss_motor_model #(
	parameter int FB_DELAY = 5,
	parameter int POLE_DELAY = 4
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	// from the supervisor
	input wire logic i_selector_cmd,
	input wire logic i_pole_detect_req,
	// fault injection from the bench
	input wire logic i_stall,
	input wire logic i_glitch,
	// to the supervisor
	output logic o_selector_fb,
	output logic o_pole_done
);
	int fb_cnt;
	int pole_cnt;
	logic fb_q;
	// a stuck contactor never follows; a glitch flips the contact one cycle
	assign o_selector_fb = fb_q ^ i_glitch;
	always @(posedge i_core_clk) begin
		o_pole_done <= 1'b0;
		if (!i_reset_n) begin
			fb_q <= 1'b0;
			fb_cnt <= 0;
			pole_cnt <= 0;
		end else begin
			if (i_selector_cmd != fb_q && !i_stall) begin
				fb_cnt <= fb_cnt + 1;
				if (fb_cnt == FB_DELAY) begin
					fb_q <= i_selector_cmd;
					fb_cnt <= 0;
				end
			end else begin
				fb_cnt <= 0;
			end
			// detection only completes with the low-speed winding on
			if (i_pole_detect_req && fb_q) begin
				pole_cnt <= pole_cnt + 1;
				o_pole_done <= (pole_cnt == POLE_DELAY);
			end else begin
				pole_cnt <= 0;
			end
		end
	end
endmodule // wss_motor_model

//--- verif/tb.sv
// self-checking bench for the winding select supervisor
// assumes short changeover and power-on check counts set by parameter
`timescale 1ns/1ps
`include "wss_params.svh"
module tb;
	localparam int CHG = 50;
	localparam int CHK = 20;
	// host switching speed and hysteresis, kept on the host side
	localparam int SWITCH_RPM = 1250;
	localparam int HYST_PCT = 5;
	logic i_core_clk, i_reset_n, i_wr, i_rd, i_servo_enable_command;
	logic i_motor_param_winding, i_pairing_ok, i_selector_fb, i_pole_done;
	logic [7:0] i_addr;
	logic [31:0] i_wdata, o_rdata, i_servo_cmd_io, o_status_io, rv, seed;
	logic [2:0] i_motor_param_type;
	logic [15:0] i_motor_speed;
	logic o_servo_on_done, o_pole_detect_req, o_selector_cmd, o_servo_enabled;
	logic o_stop_req, o_irq, stall, glitch;
	logic [5:0] o_alarm;
	logic [1:0] o_alarm_stop_method;
	int n_mismatch, num_checks, cyc, k, spd;
	wss_supervisor #(.CHANGE_CYCLES(CHG), .CHECK_CYCLES(CHK)) i_dut (
		.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_servo_enable_command(i_servo_enable_command),
		.i_servo_cmd_io(i_servo_cmd_io), .o_status_io(o_status_io),
		.o_servo_on_done(o_servo_on_done),
		.i_motor_param_type(i_motor_param_type),
		.i_motor_param_winding(i_motor_param_winding),
		.i_pairing_ok(i_pairing_ok), .i_motor_speed(i_motor_speed),
		.i_selector_fb(i_selector_fb), .i_pole_done(i_pole_done),
		.o_pole_detect_req(o_pole_detect_req), .o_selector_cmd(o_selector_cmd),
		.o_servo_enabled(o_servo_enabled), .o_alarm(o_alarm),
		.o_stop_req(o_stop_req), .o_alarm_stop_method(o_alarm_stop_method),
		.o_irq(o_irq));
	wss_motor_model i_motor (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
		.i_selector_cmd(o_selector_cmd), .i_pole_detect_req(o_pole_detect_req),
		.i_stall(stall), .i_glitch(glitch), .o_selector_fb(i_selector_fb),
		.o_pole_done(i_pole_done));
	always #5 i_core_clk = ~i_core_clk;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic pin(input int s);
		case (s)
			0: return o_pole_detect_req;
			1: return o_servo_enabled;
			2: return o_status_io[31];
			default: return o_alarm[s-3];
		endcase
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_core_clk);
		#1;
	endtask
	task automatic wait_pin(input int s, input logic v, input int n);
		for (int j = 0; j < n; j++) begin
			if (pin(s) === v) break;
			tick(1);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_core_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge i_core_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		#1;
		d = o_rdata;
	endtask
	task automatic do_reset(input logic st);
		@(posedge i_core_clk);
		i_reset_n <= 1'b0;
		stall <= st;
		i_servo_enable_command <= 1'b0;
		i_servo_cmd_io <= 32'h0;
		repeat (5) @(posedge i_core_clk);
		i_reset_n <= 1'b1;
		tick(2);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	always @(posedge i_core_clk) begin
		cyc++;
		if (cyc == 8000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end
	initial begin
		{i_core_clk, i_reset_n, i_wr, i_rd, i_servo_enable_command} = '0;
		{i_addr, i_wdata, i_servo_cmd_io, i_motor_speed} = '0;
		{i_motor_param_type, i_motor_param_winding, glitch, stall} = '0;
		i_pairing_ok = 1'b1;
		seed = 32'h634FE7B8;
		do_reset(1'b1);
		wait_pin(7, 1'b1, CHK + 20);
		chk({o_stop_req, o_alarm}, 7'h50);
		$display("power-on selector check done");
		do_reset(1'b0);
		tick(12);
		chk({o_stop_req, o_alarm}, 7'h00);
		rd(`WSS_ADDR_LOW_MAX, rv);
		chk(rv, 32'h0000FFFF);
		rd(8'hFC, rv);
		chk(rv, 32'h0);
		i_servo_enable_command <= 1'b1;
		wait_pin(8, 1'b1, 5);
		chk({o_stop_req, o_alarm, o_servo_enabled}, 8'hC0);
		i_servo_enable_command <= 1'b0;
		wait_pin(8, 1'b0, 5);
		chk({o_stop_req, o_alarm}, 7'h00);
		$display("early servo-on refused");
		wr(`WSS_ADDR_INT_MASK, 32'h40);
		i_servo_cmd_io <= 32'h80000000;
		i_servo_enable_command <= 1'b1;
		wait_pin(0, 1'b1, 5);
		chk({o_servo_enabled, o_servo_on_done}, 2'b00);
		wait_pin(1, 1'b1, 20);
		chk({o_servo_on_done, o_pole_detect_req, o_irq}, 3'b101);
		chk(o_status_io, 32'h80000000);
		wr(`WSS_ADDR_INT_STATUS, 32'h40);
		tick(2);
		chk(o_irq, 1'b0);
		i_servo_enable_command <= 1'b0;
		tick(3);
		i_servo_enable_command <= 1'b1;
		for (k = 0; k < 4; k++) begin
			tick(1);
			chk(o_pole_detect_req, 1'b0);
		end
		chk(o_servo_enabled, 1'b1);
		$display("pole detection sequence done");
		for (k = 0; k < 5; k++) begin
			seed = lfsr(seed);
			spd = int'(seed[15:0]) % 2500;
			if (k == 4)
				spd = 300;
			i_motor_speed <= 16'(spd);
			i_servo_cmd_io[31] <= (spd < SWITCH_RPM * (100 - HYST_PCT) / 100);
			tick(2);
			wait_pin(2, i_servo_cmd_io[31], 30);
			chk(o_status_io, {i_servo_cmd_io[31], 31'h0});
			chk(o_selector_cmd, i_servo_cmd_io[31]);
		end
		$display("winding changeovers done");
		wr(`WSS_ADDR_LOW_MAX, 32'd1000);
		i_motor_speed <= 16'd1500;
		wait_pin(6, 1'b1, 5);
		chk({o_stop_req, o_alarm}, 7'h48);
		i_motor_speed <= 16'd500;
		wait_pin(6, 1'b0, 5);
		chk({o_stop_req, o_alarm}, 7'h00);
		stall <= 1'b1;
		i_servo_cmd_io <= 32'h0;
		tick(CHG - 10);
		chk(o_alarm, 6'h00);
		wait_pin(7, 1'b1, 30);
		chk({o_stop_req, o_alarm}, 7'h50);
		stall <= 1'b0;
		tick(10);
		chk(o_alarm, 6'h10);
		wr(`WSS_ADDR_CTRL, 32'h5);
		tick(2);
		chk({o_alarm_stop_method, o_alarm}, 8'h80);
		@(posedge i_core_clk);
		glitch <= 1'b1;
		@(posedge i_core_clk);
		glitch <= 1'b0;
		wait_pin(7, 1'b1, 5);
		chk(o_alarm, 6'h10);
		$display("selector faults done");
		for (k = 0; k < 3; k++) begin
			wr(`WSS_ADDR_CTRL, 32'h1);
			case (k)
				0: wr(`WSS_ADDR_CONFIG, 32'h1);
				1: wr(`WSS_ADDR_CONFIG, 32'h8);
				default: i_pairing_ok <= 1'b0;
			endcase
			tick(3);
			chk(o_alarm, 6'(1 << k));
			wr(`WSS_ADDR_CONFIG, 32'h0);
			i_pairing_ok <= 1'b1;
			tick(3);
			chk(o_alarm, 6'(1 << k));
		end
		wr(`WSS_ADDR_CTRL, 32'h1);
		tick(3);
		chk(o_alarm, 6'h00);
		$display("configuration alarms done");
		do_reset(1'b0);
		tick(12);
		i_servo_cmd_io <= 32'h80000000;
		i_servo_enable_command <= 1'b1;
		wait_pin(0, 1'b1, 5);
		i_servo_cmd_io <= 32'h0;
		wait_pin(8, 1'b1, 5);
		chk({o_pole_detect_req, o_alarm, o_servo_enabled}, 8'h40);
		$display("pole abort on high-speed request done");
		tally_and_finish();
	end
endmodule // tb
